// ==== logic/ibm_monitor.sv ====
// Passive bus watch, display feed and capture forwarding
`timescale 1ns/100ps
module ibm_monitor import ibm_pkg::*; (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic sda_i, // Bus data line as seen
	input wire logic scl_i, // Bus clock line as seen
	output logic sda_o, // Bus data drive value
	output logic sda_oe, // Bus data drive enable
	output logic scl_o, // Bus clock drive value
	output logic scl_oe, // Bus clock drive enable
	input wire logic host_rxd, // Host link, characters in
	output logic host_txd, // Host link, records out
	output logic [7:0] disp_ind, // Upper-left indicator character
	output ibm_rec_t disp_rec, // Record shown on the display
	output logic disp_valid, // One-cycle pulse per new shown record
	output ibm_mode_t mode // Active mode
);
	// ==========================================================
	// Host character receiver
	logic rx_valid; // New character pulse
	logic [7:0] rx_data; // Character value

	ibm_uart_rx u_rx (
		.mclk(mclk),
		.nrst(nrst),
		.rxd(host_rxd),
		.rx_valid(rx_valid),
		.rx_data(rx_data)
	);

	// ==========================================================
	// Bus pins: the block only listens in every mode here
	// outputs never enabled
	assign sda_o = 1'b0;
	assign scl_o = 1'b0;
	assign sda_oe = 1'b0;
	assign scl_oe = 1'b0;

	// ==========================================================
	// Mode state
	ibm_mode_t mode_q, mode_d; // Current mode
	logic [7:0] ind_q, ind_d; // Indicator character

	// Mode changes from host characters
	always_comb begin
		mode_d = mode_q;
		// Hold by default so no path leaves the indicator unassigned
		ind_d = ind_q;
		if (rx_valid) begin
			unique case (mode_q)
				MODE_DRV: begin
					if (rx_data == CMD_MONITOR) begin
						mode_d = MODE_MON;
					end else if (rx_data == CMD_CAPTURE) begin
						mode_d = MODE_CAP;
					end
				end
				MODE_MON: mode_d = MODE_DRV;
				MODE_CAP: mode_d = MODE_DRV;
			endcase
		end
		unique case (mode_d)
			MODE_MON: ind_d = CH_MONITOR;
			MODE_CAP: ind_d = CH_CAPTURE;
			MODE_DRV: ind_d = CH_DRIVER;
		endcase
	end

	// Registers only
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mode_q <= MODE_DRV;
			ind_q <= CH_DRIVER;
		end else begin
			mode_q <= mode_d;
			ind_q <= ind_d;
		end
	end

	// ==========================================================
	// Bus decoder
	logic sda_s1_q, sda_s2_q, sda_s3_q; // Sync pair plus history
	logic scl_s1_q, scl_s2_q, scl_s3_q;
	logic in_frame_q, in_frame_d; // Between start and stop
	logic first_q, first_d; // Next byte is the address byte
	logic [3:0] bit_q, bit_d; // Bit index within a byte
	logic [7:0] shr_q, shr_d; // Byte being collected
	ibm_rec_t rec_q, rec_d; // Last decoded record
	logic rec_vld_q, rec_vld_d; // Record pulse
	logic start_det, stop_det, scl_rise; // Bus conditions

	// Only the second and third stages feed detection logic
	assign scl_rise = scl_s2_q && !scl_s3_q;
	assign start_det = scl_s2_q && scl_s3_q && !sda_s2_q && sda_s3_q;
	assign stop_det = scl_s2_q && scl_s3_q && sda_s2_q && !sda_s3_q;

	// Byte assembly and record building, in bus order
	always_comb begin
		in_frame_d = in_frame_q;
		first_d = first_q;
		bit_d = bit_q;
		shr_d = shr_q;
		rec_d = rec_q;
		rec_vld_d = 1'b0;
		if (start_det) begin
			// Repeated start is treated as a fresh start
			in_frame_d = 1'b1;
			first_d = 1'b1;
			bit_d = 4'h0;
		end else if (stop_det) begin
			in_frame_d = 1'b0;
			rec_d = '{ev: EV_STOP, data: 8'h00, ack: 1'b0};
			rec_vld_d = in_frame_q;
		end else if (scl_rise && in_frame_q) begin
			if (bit_q == I2C_ACK_BIT) begin
				rec_d.ev = first_q ? EV_START : EV_DATA;
				rec_d.data = shr_q;
				rec_d.ack = !sda_s2_q;
				rec_vld_d = 1'b1;
				first_d = 1'b0;
				bit_d = 4'h0;
			end else begin
				shr_d = {shr_q[6:0], sda_s2_q};
				bit_d = bit_q + 4'h1;
			end
		end
	end

	// Registers only
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			sda_s3_q <= 1'b1;
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_s3_q <= 1'b1;
			in_frame_q <= 1'b0;
			first_q <= 1'b0;
			bit_q <= 4'h0;
			shr_q <= 8'h00;
			rec_q <= '{ev: EV_NONE, data: 8'h00, ack: 1'b0};
			rec_vld_q <= 1'b0;
		end else begin
			sda_s1_q <= sda_i;
			sda_s2_q <= sda_s1_q;
			sda_s3_q <= sda_s2_q;
			scl_s1_q <= scl_i;
			scl_s2_q <= scl_s1_q;
			scl_s3_q <= scl_s2_q;
			in_frame_q <= in_frame_d;
			first_q <= first_d;
			bit_q <= bit_d;
			shr_q <= shr_d;
			rec_q <= rec_d;
			rec_vld_q <= rec_vld_d;
		end
	end

	// ==========================================================
	// Display feed and record forwarding
	ibm_rec_t disp_q, disp_d; // Record on display
	logic dvld_q, dvld_d; // Display update pulse
	logic [19:0] tx_shr_q, tx_shr_d; // Two frames, LSB first
	logic [4:0] tx_left_q, tx_left_d; // Bits still to send
	logic [5:0] tx_cnt_q, tx_cnt_d; // Cycles left in this bit
	logic tx_go; // Record accepted for sending

	// No buffer: a record arriving while a send runs is not forwarded
	assign tx_go = (mode_q == MODE_CAP) && rec_vld_q && (tx_left_q == 5'h00);

	always_comb begin
		disp_d = disp_q;
		dvld_d = 1'b0;
		tx_shr_d = tx_shr_q;
		tx_left_d = tx_left_q;
		tx_cnt_d = tx_cnt_q;
		if (rec_vld_q && mode_q == MODE_MON) begin
			disp_d = rec_q;
			dvld_d = 1'b1;
		end
		if (tx_go) begin
			tx_shr_d = {1'b1, rec_q.data, 1'b0, 1'b1, ibm_hdr(rec_q), 1'b0};
			tx_left_d = TX_FRAME_BITS;
			tx_cnt_d = BIT_CYC - 6'h01;
		end else if (tx_left_q != 5'h00) begin
			if (tx_cnt_q != 6'h00) begin
				tx_cnt_d = tx_cnt_q - 6'h01;
			end else begin
				tx_shr_d = {1'b1, tx_shr_q[19:1]};
				tx_left_d = tx_left_q - 5'h01;
				tx_cnt_d = BIT_CYC - 6'h01;
			end
		end
	end

	// Registers only
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			disp_q <= '{ev: EV_NONE, data: 8'h00, ack: 1'b0};
			dvld_q <= 1'b0;
			tx_shr_q <= 20'hF_FFFF;
			tx_left_q <= 5'h00;
			tx_cnt_q <= 6'h00;
		end else begin
			disp_q <= disp_d;
			dvld_q <= dvld_d;
			tx_shr_q <= tx_shr_d;
			tx_left_q <= tx_left_d;
			tx_cnt_q <= tx_cnt_d;
		end
	end

	assign host_txd = tx_shr_q[0];
	assign disp_rec = disp_q;
	assign disp_valid = dvld_q;
	assign disp_ind = ind_q;
	assign mode = mode_q;

	// ==========================================================
	// Checks
	// One clock domain, so one default clock and reset serve all checks
	default clocking chk_clk @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	// Start bit of a forwarded record holds low
	sequence s_tx_start;
		!host_txd [*8];
	endsequence

	a_bus_not_driven: assert property (
		!sda_oe && !scl_oe)
		else $error("bus pin driven");
	a_watch_display: assert property (
		disp_valid |-> $past(mode_q) == MODE_MON && $past(rec_vld_q))
		else $error("display update outside watch mode");
	a_display_hold: assert property (
		!disp_valid |-> $stable(disp_rec))
		else $error("display record changed without update");
	a_ind_watch: assert property (
		(mode_q == MODE_MON) == (disp_ind == CH_MONITOR))
		else $error("watch indicator wrong");
	a_enter_watch: assert property (
		rx_valid && rx_data == CMD_MONITOR && mode_q == MODE_DRV
		|=> mode_q == MODE_MON && disp_ind == CH_MONITOR)
		else $error("m did not enter watch mode");
	a_leave_mode: assert property (
		rx_valid && mode_q != MODE_DRV |=> mode_q == MODE_DRV)
		else $error("character did not leave mode");
	a_capture_send: assert property (
		tx_go |=> s_tx_start ##1 !host_txd)
		else $error("record not forwarded");
	a_ind_capture: assert property (
		(mode_q == MODE_CAP) == (disp_ind == CH_CAPTURE))
		else $error("capture indicator wrong");
	a_stop_record: assert property (
		stop_det && in_frame_q |=> rec_vld_q && rec_q.ev == EV_STOP)
		else $error("stop record missing");
	a_addr_record: assert property (
		scl_rise && in_frame_q && bit_q == I2C_ACK_BIT && first_q
		&& !start_det && !stop_det
		|=> rec_vld_q && rec_q.ev == EV_START && rec_q.data == $past(shr_q))
		else $error("start record wrong");
endmodule : ibm_monitor

// ==== logic/ibm_pkg.sv ====
// Shared constants and types of the bus monitor and capture block
package ibm_pkg;
	// ==========================================================
	// Clock and serial link timing
	localparam int CLK_HZ = 50_000_000; // System clock in Hz
	localparam int LINK_BAUD = 1_000_000; // Host link rate in baud
	// Cycles per serial bit, and the half bit used to centre sampling
	localparam logic [5:0] BIT_CYC = 6'(CLK_HZ / LINK_BAUD);
	localparam logic [5:0] HALF_CYC = 6'(CLK_HZ / LINK_BAUD / 2);
	localparam logic [2:0] LAST_DATA_BIT = 3'h7; // Eight data bits, 8N1
	localparam logic [4:0] TX_FRAME_BITS = 5'h14; // Two 10-bit frames
	localparam logic [3:0] I2C_ACK_BIT = 4'h8; // Ninth bit of each byte

	// ==========================================================
	// Characters
	localparam logic [7:0] CH_DRIVER = 8'h44; // D, normal operation
	localparam logic [7:0] CH_MONITOR = 8'h4D; // M, passive watch
	localparam logic [7:0] CH_CAPTURE = 8'h43; // C, recording
	localparam logic [7:0] CMD_MONITOR = 8'h6D; // m enters watch mode
	localparam logic [7:0] CMD_CAPTURE = 8'h63; // c enters recording

	// ==========================================================
	// Modes and record types
	typedef enum logic [2:0] {
		MODE_DRV = 3'b001,
		MODE_MON = 3'b010,
		MODE_CAP = 3'b100
	} ibm_mode_t;

	typedef enum logic [1:0] {
		EV_NONE = 2'b00,
		EV_START = 2'b01,
		EV_DATA = 2'b10,
		EV_STOP = 2'b11
	} ibm_ev_t;

	// One decoded bus event; for a start, data holds {address, r/w}
	typedef struct packed {
		ibm_ev_t ev;
		logic [7:0] data;
		logic ack;
	} ibm_rec_t;

	// Header byte of a forwarded record: type, ack, zero padding
	function automatic logic [7:0] ibm_hdr(input ibm_rec_t r);
		return {r.ev, r.ack, 5'h00};
	endfunction : ibm_hdr
endpackage : ibm_pkg

// ==== logic/ibm_uart_rx.sv ====
// Host link receiver, 8N1, one character per pulse
`timescale 1ns/100ps
module ibm_uart_rx import ibm_pkg::*; (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic rxd, // Serial input pin, idle high
	output logic rx_valid, // One-cycle pulse per good character
	output logic [7:0] rx_data // Last character received
);
	// ==========================================================
	// Receiver state
	typedef enum logic [3:0] {
		RX_IDLE = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA = 4'b0100,
		RX_STOP = 4'b1000
	} ibm_rx_st_t;

	ibm_rx_st_t st_q, st_d; // Frame position
	logic rxd_s1_q, rxd_s2_q; // Pin synchroniser
	logic [5:0] cnt_q, cnt_d; // Cycles to next sample point
	logic [2:0] bits_q, bits_d; // Data bits taken so far
	logic [7:0] shr_q, shr_d; // Data shifter, LSB first on the wire
	logic valid_q, valid_d; // Character pulse, one cycle
	logic [7:0] data_q, data_d; // Last good character

	// Next frame state; sampling at mid-bit tolerates baud mismatch
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		bits_d = bits_q;
		shr_d = shr_q;
		valid_d = 1'b0;
		data_d = data_q;
		unique case (st_q)
			RX_IDLE: begin
				if (!rxd_s2_q) begin
					st_d = RX_START;
					cnt_d = HALF_CYC - 6'h01;
				end
			end
			RX_START: begin
				if (cnt_q != 6'h00) begin
					cnt_d = cnt_q - 6'h01;
				end else if (!rxd_s2_q) begin
					st_d = RX_DATA;
					cnt_d = BIT_CYC - 6'h01;
					bits_d = 3'h0;
				end else begin
					// Glitch, not a start bit
					st_d = RX_IDLE;
				end
			end
			RX_DATA: begin
				if (cnt_q != 6'h00) begin
					cnt_d = cnt_q - 6'h01;
				end else begin
					shr_d = {rxd_s2_q, shr_q[7:1]};
					cnt_d = BIT_CYC - 6'h01;
					bits_d = bits_q + 3'h1;
					if (bits_q == LAST_DATA_BIT) begin
						st_d = RX_STOP;
					end
				end
			end
			RX_STOP: begin
				if (cnt_q != 6'h00) begin
					cnt_d = cnt_q - 6'h01;
				end else begin
					// Framing error drops the character silently
					valid_d = rxd_s2_q;
					data_d = rxd_s2_q ? shr_q : data_q;
					st_d = RX_IDLE;
				end
			end
		endcase
	end

	// Registers only
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_q <= RX_IDLE;
			rxd_s1_q <= 1'b1;
			rxd_s2_q <= 1'b1;
			cnt_q <= 6'h00;
			bits_q <= 3'h0;
			shr_q <= 8'h00;
			valid_q <= 1'b0;
			data_q <= 8'h00;
		end else begin
			st_q <= st_d;
			rxd_s1_q <= rxd;
			rxd_s2_q <= rxd_s1_q;
			cnt_q <= cnt_d;
			bits_q <= bits_d;
			shr_q <= shr_d;
			valid_q <= valid_d;
			data_q <= data_d;
		end
	end

	assign rx_valid = valid_q;
	assign rx_data = data_q;
endmodule : ibm_uart_rx

// ==== tb/ibm_far_side.sv ====
// Far side model: observed bus parties and the host terminal
`timescale 1ns/100ps
module ibm_far_side (
	input wire logic host_txd,
	output logic host_rxd,
	output logic sda_pd,
	output logic scl_pd
);
	// ==========================================================
	// Host terminal
	logic [7:0] got[$]; // Bytes heard on the record link
	logic [7:0] b; // Byte being assembled

	// Lines idle high, both bus lines released
	initial begin
		host_rxd = 1'b1;
		sda_pd = 1'b0;
		scl_pd = 1'b0;
	end

	task automatic send_char(input logic [7:0] c);
		host_rxd = 1'b0;
		#1000;
		for (int i = 0; i < 8; i++) begin
			host_rxd = c[i];
			#1000;
		end
		host_rxd = 1'b1;
		#1000;
	endtask : send_char

	// 8N1 listener, LSB first, mid-bit sampling
	initial forever begin
		@(negedge host_txd);
		#500;
		for (int i = 0; i < 8; i++) begin
			#1000;
			b[i] = host_txd;
		end
		// Land in the stop bit so the next fall is a start
		#1000;
		got.push_back(b);
	end

	// ==========================================================
	// Bus traffic, open drain; clock stands still between calls
	task automatic i2c_start();
		sda_pd = 1'b1;
		#80;
		scl_pd = 1'b1;
		#80;
	endtask : i2c_start

	// Byte MSB first, then the target's ack (pull-down = ack)
	task automatic i2c_byte(input logic [7:0] d, input logic ack);
		logic [8:0] s;
		s = {d, ~ack};
		for (int i = 8; i >= 0; i--) begin
			sda_pd = ~s[i];
			#80;
			scl_pd = 1'b0;
			#80;
			scl_pd = 1'b1;
		end
	endtask : i2c_byte

	// Data rises while the clock is high
	task automatic i2c_stop();
		sda_pd = 1'b1;
		#80;
		scl_pd = 1'b0;
		#80;
		sda_pd = 1'b0;
		#80;
	endtask : i2c_stop
endmodule : ibm_far_side

// ==== tb/tb.sv ====
// Self-checking bench of the bus monitor and capture block
`timescale 1ns/100ps
module tb;
	import ibm_pkg::*;
	// ==========================================================
	// Signals
	logic mclk, nrst;
	logic sda_o, sda_oe, scl_o, scl_oe, sda_pd, scl_pd;
	logic host_rxd, host_txd, disp_valid;
	logic [7:0] disp_ind;
	ibm_rec_t disp_rec;
	ibm_mode_t mode;
	ibm_rec_t shown[$]; // Records seen on the display
	int error_cnt = 0;
	int n_tests = 0;
	int oe_hits = 0; // Cycles with a bus drive enable up
	// Wired bus lines with pull-ups
	wire logic sda = ~(sda_oe & ~sda_o) & ~sda_pd;
	wire logic scl = ~(scl_oe & ~scl_o) & ~scl_pd;

	ibm_monitor i_ibm_monitor (.mclk(mclk), .nrst(nrst), .sda_i(sda),
		.scl_i(scl), .sda_o(sda_o), .sda_oe(sda_oe), .scl_o(scl_o),
		.scl_oe(scl_oe), .host_rxd(host_rxd), .host_txd(host_txd),
		.disp_ind(disp_ind), .disp_rec(disp_rec),
		.disp_valid(disp_valid), .mode(mode));
	ibm_far_side i_ibm_far_side (.host_txd(host_txd),
		.host_rxd(host_rxd), .sda_pd(sda_pd), .scl_pd(scl_pd));

	// 50 MHz clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// Display stream and bus drive watch
	always @(posedge mclk) begin
		if (disp_valid === 1'b1)
			shown.push_back(disp_rec);
		if (nrst === 1'b1 && (sda_oe !== 1'b0 || scl_oe !== 1'b0))
			oe_hits++;
	end

	// ==========================================================
	// Shared tasks
	task automatic chk(input string n, input logic [10:0] e,
		input logic [10:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// Wait cycles, then step off the edge
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask : idle

	// One host character, then indicator and mode
	task automatic host_chk(input logic [7:0] c, input logic [7:0] ind,
		input ibm_mode_t md);
		i_ibm_far_side.send_char(c);
		idle(4);
		chk("indicator", 11'(ind), 11'(disp_ind));
		chk("mode", 11'(md), 11'(mode));
	endtask : host_chk

	// Single ending point of the run
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		chk("indicator", 11'(CH_DRIVER), 11'(disp_ind));
		chk("mode", 11'(MODE_DRV), 11'(mode));
		chk("txd idle", 11'h001, 11'(host_txd));
		chk("drive values", 11'h000, 11'({sda_o, scl_o}));
		$display("test reset done");
	endtask : t_reset

	// Watch a read with ack then a nacked byte
	task automatic t_monitor();
		host_chk(CMD_MONITOR, CH_MONITOR, MODE_MON);
		i_ibm_far_side.i2c_start();
		i_ibm_far_side.i2c_byte(8'h91, 1'b1);
		i_ibm_far_side.i2c_byte(8'hA5, 1'b0);
		i_ibm_far_side.i2c_stop();
		idle(10);
		chk("shown count", 11'h003, 11'(shown.size()));
		chk("start rec", {EV_START, 8'h91, 1'b1}, shown[0]);
		chk("data rec", {EV_DATA, 8'hA5, 1'b0}, shown[1]);
		chk("stop rec", {EV_STOP, 8'h00, 1'b0}, shown[2]);
		chk("drive hits", 11'h000, 11'(oe_hits));
		host_chk(8'h7A, CH_DRIVER, MODE_DRV);
		$display("test monitor done");
	endtask : t_monitor

	// Ignored char in normal mode, then record forwarding
	task automatic t_capture();
		logic [7:0] ex [6];
		ex = '{{EV_START, 1'b1, 5'h00}, 8'h28, {EV_DATA, 1'b1, 5'h00},
			8'h02, {EV_STOP, 1'b0, 5'h00}, 8'h00};
		host_chk(8'h71, CH_DRIVER, MODE_DRV);
		host_chk(CMD_CAPTURE, CH_CAPTURE, MODE_CAP);
		// Gaps let each two-frame record drain before the next
		i_ibm_far_side.i2c_start();
		i_ibm_far_side.i2c_byte(8'h28, 1'b1);
		idle(1100);
		i_ibm_far_side.i2c_byte(8'h02, 1'b1);
		idle(1100);
		i_ibm_far_side.i2c_stop();
		idle(1100);
		chk("link bytes", 11'h006,
			11'(i_ibm_far_side.got.size()));
		for (int i = 0; i < 6; i++)
			chk("link byte", 11'(ex[i]),
				11'(i_ibm_far_side.got[i]));
		chk("indicator", 11'(CH_CAPTURE), 11'(disp_ind));
		chk("shown count", 11'h003, 11'(shown.size()));
		chk("drive hits", 11'h000, 11'(oe_hits));
		host_chk(8'h7A, CH_DRIVER, MODE_DRV);
		$display("test capture done");
	endtask : t_capture

	// ==========================================================
	// Main sequence
	initial begin
		nrst = 1'b0;
		repeat (5) @(posedge mclk);
		#2;
		nrst = 1'b1;
		idle(3);
		t_reset();
		t_monitor();
		t_capture();
		test_done();
	end

	// Watchdog, well past the expected run of about 125 us
	initial begin
		#1_000_000;
		error_cnt++;
		test_done();
	end
endmodule : tb
